// ==== bench/sfc_host_model.sv ====
// Host model: drives chip select and the serial clock, reads serial data on sclk falls.
// Assumes the bench calls frame() from one process; sclk stands high between frames.
`timescale 1ns/10ps
module sfc_host_model (
    input  wire logic                 i_sdo,
    input  wire logic                 i_sdo_oe_n,
    input  wire sfc_pkg::sfc_state_t  i_state,
    output logic                      o_cs_n,
    output logic                      o_sclk,
    output logic [11:0]               o_word,
    output logic                      o_tail,
    output logic                      o_oe_bad,
    output sfc_pkg::sfc_state_t       o_st_early,
    output sfc_pkg::sfc_state_t       o_st_late,
    output logic                      o_word_rdy
);
    import sfc_pkg::*;
    logic last_sdo;
    logic wire_sdo;

    // A released line shows the inverse of its last driven level, never a stale copy
    assign wire_sdo = i_sdo_oe_n ? ~last_sdo : i_sdo;
    always @(i_sdo or i_sdo_oe_n) begin
        if (!i_sdo_oe_n) last_sdo = i_sdo;
    end

    initial begin
        last_sdo = 1'b0;
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_word = 12'h000;
        o_tail = 1'b0;
        o_oe_bad = 1'b0;
        o_word_rdy = 1'b0;
        o_st_early = ACQUIRE_STATE;
        o_st_late = ACQUIRE_STATE;
    end

    // One frame of n sclk falls; 80 ns period, data read as sclk falls
    task automatic frame(input int n);
        int k;
        o_word = 12'h000;
        o_tail = 1'b0;
        o_oe_bad = 1'b0;
        #3 o_cs_n = 1'b0;
        #40;
        for (k = 1; k <= n; k++) begin
            o_sclk = 1'b0;
            o_oe_bad = o_oe_bad | i_sdo_oe_n;
            if (k == 1) o_tail = wire_sdo;
            else if (k <= 13) o_word = {o_word[10:0], wire_sdo};
            else o_tail = o_tail | wire_sdo;
            if (k == 5) o_st_early = i_state;
            if (k == 19) o_st_late = i_state;
            #40 o_sclk = 1'b1;
            #40;
        end
        o_cs_n = 1'b1;
        if (n >= 13) begin
            o_word_rdy = 1'b1;
            #1 o_word_rdy = 1'b0;
        end
    endtask
endmodule

// ==== bench/test_sfc_frame_ctrl.sv ====
// Self-checking bench for the serial-frame control, host model on the link side.
// Assumes the design package is compiled first; expectations are queued per frame.
`timescale 1ns/10ps
module test_sfc_frame_ctrl;
    import sfc_pkg::*;
    localparam int CAL_N = 8;
    logic        i_clk, i_rst, cs_n, sclk, sdo, sdo_oe_n, ain_connect, word_rdy, tail, oe_bad;
    logic [11:0] ain, meas, offset, word, prev, cur_off;
    sfc_state_t  state, st_early, st_late;
    logic [12:0] exp_q[$];
    int          mismatches, total_checks, seed, i;
    bit          first;

    sfc_frame_ctrl #(.CAL_CYCLES(CAL_N)) sfc_frame_ctrl_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_ain_code(ain), .i_offset_meas(meas), .o_sdo(sdo),
        .o_sdo_oe_n(sdo_oe_n), .o_ain_connect(ain_connect), .o_state(state), .o_offset(offset));
    sfc_host_model sfc_host_model_inst (.i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .i_state(state),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_word(word), .o_tail(tail), .o_oe_bad(oe_bad),
        .o_st_early(st_early), .o_st_late(st_late), .o_word_rdy(word_rdy));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Two's complement difference, clamped to the code range
    function automatic logic [11:0] sat_sub(input logic [11:0] a, input logic [11:0] b);
        logic signed [12:0] d;
        d = $signed({a[11], a}) - $signed({b[11], b});
        if (d > 13'sd2047) return CODE_POS_FS;
        if (d < -13'sd2048) return CODE_NEG_FS;
        return d[11:0];
    endfunction

    task automatic do_reset;
        @(posedge i_clk) i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        prev = 12'h000;
        cur_off = 12'h000;
        first = 1'b1;
    endtask

    task automatic run(input int n, input logic [11:0] a);
        bit cal;
        int w;
        cal = first ? (n >= 24) : (n >= 64);
        @(posedge i_clk) ain <= a;
        if (n >= 13) exp_q.push_back({1'b0, prev});
        @(posedge i_clk);
        sfc_host_model_inst.frame(n);
        #1 check({12'h000, oe_bad}, 13'h0000);
        check({12'h000, sdo_oe_n}, 13'h0001);
        check({11'h000, st_early}, {11'h000, CONVERT_STATE});
        if (n >= 20) check({11'h000, st_late}, {11'h000, ACQUIRE_STATE});
        if (n >= 15) prev = sat_sub(a, cur_off);
        first = 1'b0;
        w = 0;
        if (cal) begin
            while (state !== OFFSET_CAL_STATE && w < 10) begin
                @(negedge i_clk);
                w++;
            end
            check({12'h000, ain_connect}, 13'h0000);
            while (state !== ACQUIRE_STATE && w < CAL_N + 20) begin
                @(negedge i_clk);
                w++;
            end
            cur_off = meas;
        end
        repeat (10) @(negedge i_clk);
        check({11'h000, state}, {11'h000, ACQUIRE_STATE});
        check({12'h000, ain_connect}, 13'h0001);
        check({1'b0, offset}, {1'b0, cur_off});
    endtask

    always @(posedge word_rdy) begin
        if (exp_q.size() == 0) check(13'h1fff, 13'h0000);
        else check({tail, word}, exp_q.pop_front());
    end

    initial begin
        #300000;
        mismatches++;
        wrap_up();
    end

    initial begin
        i_rst = 1'b1;
        ain = 12'h000;
        meas = 12'h000;
        mismatches = 0;
        total_checks = 0;
        seed = $urandom(32'hfe25612f);
        do_reset();
        run(20, 12'h123);
        do_reset();
        @(posedge i_clk) meas <= 12'($urandom);
        run(24, 12'h7ff);
        run(16, CODE_POS_FS);
        run(15, CODE_NEG_FS);
        run(16, CODE_MID);
        for (i = 0; i < 6; i++) run(13 + (i % 8), 12'($urandom));
        run(10, 12'h3a5);
        run(16, 12'h456);
        @(posedge i_clk) meas <= 12'($urandom);
        run(64, 12'($urandom));
        run(40, 12'($urandom));
        run(16, 12'($urandom));
        run(16, 12'($urandom));
        wrap_up();
    end
endmodule

// ==== design/sfc_frame_ctrl.sv ====
// Top of the serial-frame control: link logic on the serial clock, device state on i_clk.
// Assumes the host keeps chip select and the serial clock within the frame timing.
`timescale 1ns/10ps
module sfc_frame_ctrl #(
    parameter int CAL_CYCLES = sfc_pkg::CAL_CYCLES
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_cs_n,
    input  wire logic                        i_sclk,
    input  wire logic [sfc_pkg::DATA_W-1:0]  i_ain_code,
    input  wire logic [sfc_pkg::DATA_W-1:0]  i_offset_meas,
    output logic                             o_sdo,
    output logic                             o_sdo_oe_n,
    output logic                             o_ain_connect,
    output sfc_pkg::sfc_state_t              o_state,
    output logic      [sfc_pkg::DATA_W-1:0]  o_offset
);
    import sfc_pkg::*;

    localparam logic [CAL_CNT_W-1:0] CAL_LOAD = CAL_CNT_W'(CAL_CYCLES - 1);

    // Link side
    logic                 frame_rst;
    logic [CNT_W-1:0]     fall_cnt_reg;
    logic                 seen_reg;
    logic                 first_frame_reg;
    logic                 conv_tog_reg;
    logic                 cal_tog_reg;
    logic                 sdo_reg;
    logic [DATA_W-1:0]    result_word;
    logic                 cal_hit;

    // System side
    logic [2:0]           sync1_reg;
    logic [2:0]           sync2_reg;
    logic [2:0]           sync3_reg;
    logic                 cs_fall;
    logic                 cs_rise;
    logic                 conv_evt;
    logic                 cal_evt;
    sfc_state_t           state_reg;
    logic [CAL_CNT_W-1:0] cal_cnt_reg;
    logic [DATA_W-1:0]    meas1_reg;
    logic [DATA_W-1:0]    meas2_reg;
    logic [DATA_W-1:0]    offset_reg;

    // Everything frame-local clears while chip select is high
    assign frame_rst = i_cs_n | i_rst;

    // Serial clock domain
    // Falls count and step the converter; rises launch data.
    // Frame-local state clears while chip select is high.

    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            fall_cnt_reg <= CNT_ZERO;
        end else if (fall_cnt_reg != CNT_MAX) begin
            fall_cnt_reg <= fall_cnt_reg + CNT_ONE;
        end
    end

    // First-frame flag is fixed on the first fall of each frame
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            seen_reg        <= 1'b0;
            first_frame_reg <= 1'b1;
        end else begin
            seen_reg <= 1'b1;
            if (fall_cnt_reg == CNT_ZERO) begin
                first_frame_reg <= !seen_reg;
            end
        end
    end

    always_comb begin
        if (first_frame_reg) begin
            cal_hit = (fall_cnt_reg == CAL_PWRUP_LAST);
        end else begin
            cal_hit = (fall_cnt_reg == CAL_RUN_LAST);
        end
    end

    // Toggles carry conversion-done and calibration-request events out
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            conv_tog_reg <= 1'b0;
            cal_tog_reg  <= 1'b0;
        end else begin
            if (fall_cnt_reg == CONV_LAST) begin
                conv_tog_reg <= !conv_tog_reg;
            end
            if (cal_hit) begin
                cal_tog_reg <= !cal_tog_reg;
            end
        end
    end

    // Offset word only changes during calibration, while no frame samples it
    sfc_sar_core u_sar (
        .i_rst       (i_rst),
        .i_cs_n      (i_cs_n),
        .i_sclk      (i_sclk),
        .i_frame_rst (frame_rst),
        .i_fall_cnt  (fall_cnt_reg),
        .i_ain_code  (i_ain_code),
        .i_offset    (offset_reg),
        .o_result    (result_word)
    );

    // Leading zero from chip-select fall, then MSB first, then zeros
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            sdo_reg <= 1'b0;
        end else if (fall_cnt_reg != CNT_ZERO && fall_cnt_reg <= DATA_CNT) begin
            sdo_reg <= |(result_word & sfc_bit_mask(fall_cnt_reg - CNT_ONE));
        end else begin
            sdo_reg <= 1'b0;
        end
    end

    assign o_sdo      = sdo_reg;
    assign o_sdo_oe_n = i_cs_n;

    // System clock domain
    // Chip select and the two event toggles cross through three flops each;
    // the state logic only compares the second and third stages.

    // Bit 0 chip select, bit 1 conversion toggle, bit 2 calibration toggle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
            sync3_reg <= SYNC_RST;
        end else begin
            sync1_reg <= {cal_tog_reg, conv_tog_reg, i_cs_n};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign cs_fall  = sync3_reg[0] & !sync2_reg[0];
    assign cs_rise  = !sync3_reg[0] & sync2_reg[0];
    assign conv_evt = sync3_reg[1] ^ sync2_reg[1];
    assign cal_evt  = sync3_reg[2] ^ sync2_reg[2];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ACQUIRE_STATE;
        end else begin
            case (state_reg)
                ACQUIRE_STATE: begin
                    if (cal_evt) begin
                        state_reg <= OFFSET_CAL_STATE;
                    end else if (cs_fall) begin
                        state_reg <= CONVERT_STATE;
                    end
                end
                CONVERT_STATE: begin
                    if (cal_evt) begin
                        state_reg <= OFFSET_CAL_STATE;
                    end else if (conv_evt || cs_rise) begin
                        state_reg <= ACQUIRE_STATE;
                    end
                end
                OFFSET_CAL_STATE: begin
                    if (cal_cnt_reg == CAL_ZERO) begin
                        state_reg <= ACQUIRE_STATE;
                    end
                end
                default: begin
                    state_reg <= ACQUIRE_STATE;
                end
            endcase
        end
    end

    // Calibration length counter
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cal_cnt_reg <= CAL_ZERO;
        end else if (cal_evt && state_reg != OFFSET_CAL_STATE) begin
            cal_cnt_reg <= CAL_LOAD;
        end else if (state_reg == OFFSET_CAL_STATE && cal_cnt_reg != CAL_ZERO) begin
            cal_cnt_reg <= cal_cnt_reg - 8'h01;
        end
    end

    // Offset seen with the inputs disconnected
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meas1_reg <= CODE_MID;
            meas2_reg <= CODE_MID;
        end else begin
            meas1_reg <= i_offset_meas;
            meas2_reg <= meas1_reg;
        end
    end

    // Correction is kept until the next completed calibration or reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            offset_reg <= CODE_MID;
        end else if (state_reg == OFFSET_CAL_STATE && cal_cnt_reg == CAL_ZERO) begin
            offset_reg <= meas2_reg;
        end
    end

    assign o_ain_connect = (state_reg != OFFSET_CAL_STATE);
    assign o_state       = state_reg;
    assign o_offset      = offset_reg;

    // Checks, serial clock domain
    // Disabled while chip select is high, since frame state is held in reset then.
    // Request checks look at the rise after the request fall, which every frame has.

    property p_lead_zero;
        @(negedge i_sclk) disable iff (frame_rst)
        (fall_cnt_reg == CNT_ZERO) |-> !o_sdo;
    endproperty
    AST_LEAD_ZERO: assert property (p_lead_zero)
        else $error("serial data not zero before the first fall");

    property p_data_bit;
        @(negedge i_sclk) disable iff (frame_rst)
        (fall_cnt_reg != CNT_ZERO && fall_cnt_reg <= DATA_CNT)
            |-> (o_sdo == |(result_word & sfc_bit_mask(fall_cnt_reg - CNT_ONE)));
    endproperty
    AST_DATA_BIT: assert property (p_data_bit)
        else $error("serial data bit out of order");

    property p_tail_zero;
        @(negedge i_sclk) disable iff (frame_rst)
        (fall_cnt_reg > DATA_CNT) |-> !o_sdo;
    endproperty
    AST_TAIL_ZERO: assert property (p_tail_zero)
        else $error("serial data not zero after the result bits");

    property p_first_zero;
        @(negedge i_sclk) disable iff (frame_rst)
        !seen_reg |-> (result_word == RESULT_RST);
    endproperty
    AST_FIRST_ZERO: assert property (p_first_zero)
        else $error("first frame result is not all zeros");

    property p_conv_done;
        @(negedge i_sclk) disable iff (frame_rst)
        (fall_cnt_reg == CONV_LAST) |=> (conv_tog_reg != $past(conv_tog_reg));
    endproperty
    AST_CONV_DONE: assert property (p_conv_done)
        else $error("no conversion-done event on the 15th fall");

    property p_cal_pwrup;
        @(posedge i_sclk) disable iff (frame_rst)
        (first_frame_reg && fall_cnt_reg == CAL_PWRUP_LAST + CNT_ONE)
            |-> (cal_tog_reg != $past(cal_tog_reg));
    endproperty
    AST_CAL_PWRUP: assert property (p_cal_pwrup)
        else $error("24th fall of first frame did not request calibration");

    property p_cal_run;
        @(posedge i_sclk) disable iff (frame_rst)
        (!first_frame_reg && fall_cnt_reg == CAL_RUN_LAST + CNT_ONE)
            |-> (cal_tog_reg != $past(cal_tog_reg));
    endproperty
    AST_CAL_RUN: assert property (p_cal_run)
        else $error("64th fall did not request calibration");

    property p_no_early_cal;
        @(negedge i_sclk) disable iff (frame_rst)
        (!first_frame_reg && fall_cnt_reg != CAL_RUN_LAST) |=> $stable(cal_tog_reg);
    endproperty
    AST_NO_EARLY_CAL: assert property (p_no_early_cal)
        else $error("calibration requested before 64 falls");

    // Checks, system clock domain
    // Link events arrive here two to three cycles after they happen on the link.
    // The busy window checks four cycles, the shortest calibration that is safe.

    sequence s_cal_entry;
        cal_evt && state_reg != OFFSET_CAL_STATE;
    endsequence

    sequence s_cal_busy;
        (state_reg == OFFSET_CAL_STATE && !o_ain_connect)[*4];
    endsequence

    AST_CAL_ISOLATE: assert property (@(posedge i_clk) disable iff (i_rst)
        s_cal_entry |=> s_cal_busy)
        else $error("calibration did not hold the inputs disconnected");

    AST_CAL_END: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == OFFSET_CAL_STATE && cal_cnt_reg == CAL_ZERO)
            |=> (state_reg == ACQUIRE_STATE && o_offset == $past(meas2_reg)))
        else $error("calibration end did not store offset and acquire");

    AST_OFFSET_KEPT: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg != OFFSET_CAL_STATE) |=> $stable(offset_reg))
        else $error("offset correction changed outside calibration");

    AST_CS_FALL_CONV: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == ACQUIRE_STATE && cs_fall && !cal_evt) |=> (state_reg == CONVERT_STATE))
        else $error("chip-select fall did not start a conversion");

    AST_CONV_BACK: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == CONVERT_STATE && conv_evt && !cal_evt) |=> (state_reg == ACQUIRE_STATE))
        else $error("conversion end did not return to acquire");

    AST_ABORT: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == CONVERT_STATE && cs_rise && !cal_evt) |=> (state_reg == ACQUIRE_STATE))
        else $error("early chip-select rise did not return to acquire");
endmodule

// ==== design/sfc_pkg.sv ====
// Constants, types and helpers for the serial-frame control of a 12-bit SAR converter.
// Assumes a host that drives chip select and the serial clock.
// Function
// - Acquire state after power-up, after each conversion and after calibration.
// - Chip-select fall samples the input and moves acquire to convert.
// - After the 15th fall, return to acquire without any command.
// - First frame after power-up shifts out all zeros.
// - Each frame shifts out the result of the previous conversion.
// - Chip-select fall drives a leading zero on serial data.
// - MSB launched on rise after first fall, next bits on following rises.
// - After 12 result bits, further rises in the frame drive zeros.
// - Fewer than 15 falls makes the next frame's result invalid.
// - Calibration disconnects the inputs, measures and corrects internal offset.
// - Completed offset correction stays applied until power is removed.
// - 24 clocks in the first frame enter offset calibration.
// - Serial data is zero while calibration runs.
// - Chip select rising before 24 clocks in first frame aborts calibration.
// - 64 clocks in a normal frame enter offset calibration.
// - Normal calibration frame gives previous result first, then zeros.
// - Chip select rising between 15 and 64 clocks aborts calibration.
// - Serial data is high impedance while chip select is high.
// - A frame runs from chip-select fall to rise; one conversion each.
// - Result is two's complement: 800 negative, 000 mid, 7ff positive full scale.
package sfc_pkg;
    localparam int          DATA_W          = 12;
    localparam int          CNT_W           = 7;
    localparam int          CAL_CNT_W       = 8;
    localparam logic [6:0]  CNT_ZERO        = 7'h00;
    localparam logic [6:0]  CNT_ONE         = 7'h01;
    localparam logic [6:0]  CNT_MAX         = 7'h7f;
    localparam logic [6:0]  DATA_CNT        = 7'h0c;
    localparam logic [6:0]  CONV_LAST       = 7'h0e;
    localparam logic [6:0]  CAL_PWRUP_LAST  = 7'h17;
    localparam logic [6:0]  CAL_RUN_LAST    = 7'h3f;
    localparam logic [11:0] CODE_NEG_FS     = 12'h800;
    localparam logic [11:0] CODE_MID        = 12'h000;
    localparam logic [11:0] CODE_POS_FS     = 12'h7ff;
    localparam logic [11:0] RESULT_RST      = 12'h000;
    localparam logic [2:0]  SYNC_RST        = 3'h1;
    localparam logic [7:0]  CAL_ZERO        = 8'h00;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          CAL_TIME_NS     = 400;
    localparam int          CAL_CYCLES      = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ACQUIRE_STATE    = 2'b00,
        CONVERT_STATE    = 2'b01,
        OFFSET_CAL_STATE = 2'b10
    } sfc_state_t;

    // One-hot weight of result bit idx, counted from the MSB
    function automatic logic [11:0] sfc_bit_mask(input logic [6:0] idx);
        sfc_bit_mask = CODE_NEG_FS >> idx;
    endfunction
endpackage

// ==== design/sfc_sar_core.sv ====
// Successive-approximation engine stepped by serial clock falls.
// Assumes a frame reset that is high while chip select is high.
`timescale 1ns/10ps
module sfc_sar_core (
    input  wire logic                        i_rst,
    input  wire logic                        i_cs_n,
    input  wire logic                        i_sclk,
    input  wire logic                        i_frame_rst,
    input  wire logic [sfc_pkg::CNT_W-1:0]   i_fall_cnt,
    input  wire logic [sfc_pkg::DATA_W-1:0]  i_ain_code,
    input  wire logic [sfc_pkg::DATA_W-1:0]  i_offset,
    output logic      [sfc_pkg::DATA_W-1:0]  o_result
);
    import sfc_pkg::*;

    logic [DATA_W-1:0] hold_reg;
    logic [DATA_W-1:0] sar_reg;
    logic [DATA_W-1:0] target;
    logic [DATA_W-1:0] trial;
    logic [DATA_W:0]   diff;

    // Sample-and-hold closes on the chip-select falling edge
    always_ff @(negedge i_cs_n or posedge i_rst) begin
        if (i_rst) begin
            hold_reg <= CODE_MID;
        end else begin
            hold_reg <= i_ain_code;
        end
    end

    // Offset removal with saturation at the code limits
    always_comb begin
        diff = {hold_reg[DATA_W-1], hold_reg} - {i_offset[DATA_W-1], i_offset};
        if (diff[DATA_W] != diff[DATA_W-1]) begin
            target = diff[DATA_W] ? CODE_NEG_FS : CODE_POS_FS;
        end else begin
            target = diff[DATA_W-1:0];
        end
        trial = sar_reg | sfc_bit_mask(i_fall_cnt);
    end

    // Compare in offset binary, one bit per fall
    always_ff @(negedge i_sclk or posedge i_frame_rst) begin
        if (i_frame_rst) begin
            sar_reg <= CODE_MID;
        end else if (i_fall_cnt < DATA_CNT) begin
            if ((target ^ CODE_NEG_FS) >= trial) begin
                sar_reg <= trial;
            end
        end
    end

    // Result only updates on the 15th fall; a short frame leaves a stale word
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            o_result <= RESULT_RST;
        end else if (i_fall_cnt == CONV_LAST) begin
            o_result <= sar_reg ^ CODE_NEG_FS;
        end
    end

    property p_result_latch;
        @(negedge i_sclk) disable iff (i_frame_rst)
        (i_fall_cnt == CONV_LAST) |=> (o_result == ($past(sar_reg) ^ CODE_NEG_FS));
    endproperty
    AST_RESULT_LATCH: assert property (p_result_latch)
        else $error("result not taken from the SAR word on the 15th fall");

    property p_result_still;
        @(negedge i_sclk) disable iff (i_frame_rst)
        (i_fall_cnt < CONV_LAST) |=> $stable(o_result);
    endproperty
    AST_RESULT_STILL: assert property (p_result_still)
        else $error("result word changed before the 15th fall");
endmodule
